//--- pkg/prwc_pkg.sv
// constants, state enum and pin carrier for the port, reset and wake block
// assumes one 100 MHz clock and a plain 4-bit register port
package prwc_pkg;
  // register indices on the local register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_P5_DATA = 4'h1;
  localparam logic [3:0] REG_P6_DATA = 4'h2;
  localparam logic [3:0] REG_IRQ_FLAG = 4'h3;
  localparam logic [3:0] REG_P5_DIR = 4'h4;
  localparam logic [3:0] REG_P6_DIR = 4'h5;
  localparam logic [3:0] REG_TIMER_SETUP = 4'h6;
  localparam logic [3:0] REG_PRESC_COUNT = 4'h7;
  localparam logic [3:0] REG_PULLDOWN = 4'h8;
  localparam logic [3:0] REG_OPENDRAIN = 4'h9;
  localparam logic [3:0] REG_PULLUP = 4'ha;
  localparam logic [3:0] REG_WDOG_CTRL = 4'hb;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  // field positions
  localparam int ST_TIMEOUT_BIT = 4;
  localparam int ST_PWRDN_BIT = 3;
  localparam int TS_GIE_BIT = 6;
  localparam int TS_PAB_BIT = 3;
  localparam int WD_EN_BIT = 7;
  localparam int WD_EIS_BIT = 6;
  localparam int WD_ROC_BIT = 4;
  localparam int IRQ_TCC_BIT = 0;
  localparam int IRQ_CHG_BIT = 1;
  localparam int IRQ_EXT_BIT = 2;
  // reset values
  localparam logic [3:0] P5_DIR_RST = 4'hf;
  localparam logic [7:0] P6_DIR_RST = 8'hff;
  localparam logic [7:0] TIMER_SETUP_RST = 8'hbf;
  localparam logic [7:0] PRESC_RST = 8'hff;
  localparam logic [7:0] PULLDOWN_RST = 8'hff;
  localparam logic [7:0] OPENDRAIN_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'hff;
  localparam logic [7:0] WDOG_SET_MASK = 8'h80;
  localparam logic [7:0] WDOG_CLR_MASK = 8'h50;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [3:0] ROPT_PINS = 4'h3;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [9:0] PC_VECTOR = 10'h008;
  localparam logic [7:0] WDT_LIMIT = 8'hff;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OST_MS = 18;
  localparam int OST_CYCLES = (OST_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 21;

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} prwc_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu_en;
    logic [3:0] pd_en;
  } prwc_p6_pins_t;
endpackage

//--- hw/prwc_top.sv
// port 5/6 pad control, reset sequencing, watchdog and sleep/wake control
// assumes synchronous pin inputs, reset = power-on, core obeys pc_load/core_reset
//
// Summary of operation
// - two tri-state ports, per-pin direction bits
// - direction one floats pin, zero drives
// - port 6 pull-up and open-drain per pin
// - pull-downs on port5 bits0-2, port6 bits0-3
// - r-option sense pins when enable bit set
// - port 6 change raises irq or wakes
// - change wake with irqs on jumps vector
// - change wake with irqs off continues
// - reset from power-on, pin low, watchdog
// - hold reset one start-up timer period
// - reset loads program counter with zero
// - reset makes every port pin input
// - reset clears watchdog and prescaler
// - power-on clears status top three bits
// - timer setup all ones except bit6
// - prescaler, pulls ones; open-drain cleared
// - watchdog ctrl and irq bits initialised
// - sleep entry clears watchdog, keeps counting
// - pin/watchdog wake resets, change wake continues
// - timeout and power-down flags show source
// - watchdog re-enabled after any wake
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module prwc_top #(
  parameter int HOLD_CYCLES = prwc_pkg::OST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata_ff,
  input wire logic reset_pin_n,
  input wire logic hw_wdt_opt,
  input wire logic wdt_tick,
  input wire logic tcc_ovf,
  input wire logic sleep_instr,
  input wire logic gie_on_instr,
  input wire logic gie_off_instr,
  input wire logic wdt_clear_instr,
  input wire logic [3:0] p5_in,
  output logic [3:0] p5_out_ff,
  output logic [3:0] p5_oe_ff,
  output logic [2:0] p5_pd_en_ff,
  output logic [1:0] r_sense_en_ff,
  input wire logic [7:0] p6_in,
  output prwc_pkg::prwc_p6_pins_t p6_pins_ff,
  output logic core_reset_ff,
  output logic sleep_ff,
  output logic irq_req_ff,
  output logic pc_load_ff,
  output logic [9:0] pc_value_ff
);
  default clocking cb_sys @(posedge sys_clk); endclocking
  default disable iff (reset);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction

  // prescaler down-counts; ratio met when elapsed ticks divide by 2^psr
  function automatic logic rate_hit(input logic [7:0] cnt, input logic [2:0] psr);
    logic [7:0] mask;
    mask = 8'((9'h001 << psr) - 9'h001);
    rate_hit = (((~cnt) & mask) == 8'h00);
  endfunction

  prwc_pkg::prwc_state_t st_ff, nxt_st;
  logic [prwc_pkg::HOLD_W-1:0] hold_ff;
  logic [7:0] stat_ff, ts_ff, presc_ff, pd_ff, od_ff, pu_ff, wd_ff, p6_dir_ff, p6_dout_ff;
  logic [7:0] snap_ff, wdt_ff, rd_mux;
  logic [3:0] p5_dir_ff, p5_dout_ff;
  logic [2:0] flag_ff, mask_ff;
  logic p60_prev_ff;

  // event decode
  wire in_run = (st_ff == prwc_pkg::ST_RUN);
  wire in_sleep = (st_ff == prwc_pkg::ST_SLEEP);
  wire in_hold = (st_ff == prwc_pkg::ST_HOLD);
  wire wr_stat = wr_en & hit(addr, prwc_pkg::REG_STATUS);
  wire wr_p5 = wr_en & hit(addr, prwc_pkg::REG_P5_DATA);
  wire wr_p6 = wr_en & hit(addr, prwc_pkg::REG_P6_DATA);
  wire rd_p6 = rd_en & hit(addr, prwc_pkg::REG_P6_DATA);
  wire wr_flag = wr_en & hit(addr, prwc_pkg::REG_IRQ_FLAG);
  wire wr_p5dir = wr_en & hit(addr, prwc_pkg::REG_P5_DIR);
  wire wr_p6dir = wr_en & hit(addr, prwc_pkg::REG_P6_DIR);
  wire wr_ts = wr_en & hit(addr, prwc_pkg::REG_TIMER_SETUP);
  wire wr_pd = wr_en & hit(addr, prwc_pkg::REG_PULLDOWN);
  wire wr_od = wr_en & hit(addr, prwc_pkg::REG_OPENDRAIN);
  wire wr_pu = wr_en & hit(addr, prwc_pkg::REG_PULLUP);
  wire wr_wd = wr_en & hit(addr, prwc_pkg::REG_WDOG_CTRL);
  wire wr_mask = wr_en & hit(addr, prwc_pkg::REG_IRQ_MASK);
  wire gie = ts_ff[prwc_pkg::TS_GIE_BIT];
  wire resistor_option_enable = wd_ff[prwc_pkg::WD_ROC_BIT];
  wire eis = wd_ff[prwc_pkg::WD_EIS_BIT];
  wire sleep_entry = in_run & sleep_instr;
  // watchdog needs both hardware option and enable bit
  wire wdt_run = hw_wdt_opt & wd_ff[prwc_pkg::WD_EN_BIT] & ~in_hold;
  wire wdt_clr = (in_run & wdt_clear_instr) | sleep_entry;
  wire presc_wdt = ts_ff[prwc_pkg::TS_PAB_BIT];
  wire [7:0] presc_dec = presc_ff - 8'h01;
  wire wdt_adv = wdt_run & wdt_tick & (~presc_wdt | rate_hit(presc_dec, ts_ff[2:0]));
  wire wdt_timeout = wdt_adv & (wdt_ff == prwc_pkg::WDT_LIMIT);
  // pin low or watchdog expiry re-enters reset
  wire soft_rst = ~reset_pin_n | wdt_timeout;
  wire init_all = reset | soft_rst;
  // compare pins against last port 6 read
  wire p6_changed = (p6_in != snap_ff);
  wire ext_fall = eis & p60_prev_ff & ~p6_in[0];
  wire [2:0] flag_set = {ext_fall, p6_changed, tcc_ovf};
  wire [2:0] pend = flag_ff & mask_ff;
  // enabled change flag wakes the core
  wire wake_port = in_sleep & pend[prwc_pkg::IRQ_CHG_BIT];
  // irqs off: wake skips the vector
  wire take_vector = wake_port & gie;
  wire hold_done = (hold_ff == '0);

  // reset hold, run and sleep sequencing
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      prwc_pkg::ST_HOLD: begin
        // leave only after the full hold period
        if (hold_done) nxt_st = prwc_pkg::ST_RUN;
      end
      prwc_pkg::ST_RUN: begin
        if (sleep_instr) nxt_st = prwc_pkg::ST_SLEEP;
      end
      prwc_pkg::ST_SLEEP: begin
        if (wake_port) nxt_st = prwc_pkg::ST_RUN;
      end
    endcase
    // pin or watchdog wake forces reset
    if (soft_rst) nxt_st = prwc_pkg::ST_HOLD;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= prwc_pkg::ST_HOLD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // hold counter rearms while a reset source stays active
  always_ff @(posedge sys_clk) begin
    if (init_all) begin
      hold_ff <= prwc_pkg::HOLD_W'(HOLD_CYCLES - 1);
    end else if (in_hold && !hold_done) begin
      hold_ff <= hold_ff - 1'b1;
    end
  end

  // watchdog and prescaler cleared by reset
  always_ff @(posedge sys_clk) begin
    if (init_all || wdt_clr) begin
      presc_ff <= prwc_pkg::PRESC_RST;
      wdt_ff <= 8'h00;
    end else begin
      if (wdt_run && wdt_tick && presc_wdt) presc_ff <= presc_dec;
      if (wdt_adv) wdt_ff <= wdt_ff + 8'h01;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (init_all) begin
      p5_dir_ff <= prwc_pkg::P5_DIR_RST;
      p6_dir_ff <= prwc_pkg::P6_DIR_RST;
      // timer setup ones except global irq
      ts_ff <= prwc_pkg::TIMER_SETUP_RST;
      pd_ff <= prwc_pkg::PULLDOWN_RST;
      pu_ff <= prwc_pkg::PULLUP_RST;
      od_ff <= prwc_pkg::OPENDRAIN_RST;
      // enable set, ext-pin and r-option cleared
      wd_ff <= (wd_ff | prwc_pkg::WDOG_SET_MASK) & ~prwc_pkg::WDOG_CLR_MASK;
      mask_ff <= prwc_pkg::IRQ_RST;
    end else begin
      if (wr_p5dir) p5_dir_ff <= wdata[3:0];
      if (wr_p6dir) p6_dir_ff <= wdata;
      if (wr_pd) pd_ff <= wdata;
      if (wr_pu) pu_ff <= wdata;
      if (wr_od) od_ff <= wdata;
      if (wr_mask) mask_ff <= wdata[2:0];
      if (wake_port) wd_ff <= wd_ff | prwc_pkg::WDOG_SET_MASK;
      else if (wr_wd) wd_ff <= wdata;
      // vector entry masks further interrupts, like a taken irq
      if (take_vector || (in_run && gie_off_instr)) begin
        ts_ff <= {ts_ff[7], 1'b0, ts_ff[5:0]};
      end else if (in_run && gie_on_instr) begin
        ts_ff <= {ts_ff[7], 1'b1, ts_ff[5:0]};
      end else if (wr_ts) begin
        ts_ff <= wdata;
      end
    end
  end

  // port data latches keep their value across every reset kind
  always_ff @(posedge sys_clk) begin
    if (wr_p5) p5_dout_ff <= wdata[3:0];
    if (wr_p6) p6_dout_ff <= wdata;
    // snapshot also loads in reset, so no unknown level flags a change
    if (rd_p6 || init_all) snap_ff <= p6_in;
    p60_prev_ff <= p6_in[0];
  end

  // flags cleared on reset; hardware set beats software clear
  always_ff @(posedge sys_clk) begin
    if (init_all) begin
      flag_ff <= prwc_pkg::IRQ_RST;
    end else if (wr_flag) begin
      flag_ff <= wdata[2:0] | flag_set;
    end else begin
      flag_ff <= flag_ff | flag_set;
    end
  end

  // timeout and power-down flags record the cause
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // power-on clears the top three bits
      stat_ff <= prwc_pkg::STATUS_POR;
    end else if (wdt_timeout) begin
      stat_ff[prwc_pkg::ST_TIMEOUT_BIT] <= 1'b0;
      stat_ff[prwc_pkg::ST_PWRDN_BIT] <= ~in_sleep;
    end else if (sleep_entry) begin
      stat_ff[prwc_pkg::ST_TIMEOUT_BIT] <= 1'b1;
      stat_ff[prwc_pkg::ST_PWRDN_BIT] <= 1'b0;
    end else if (in_run && wdt_clear_instr) begin
      stat_ff[prwc_pkg::ST_TIMEOUT_BIT] <= 1'b1;
      stat_ff[prwc_pkg::ST_PWRDN_BIT] <= 1'b1;
    end else if (wr_stat) begin
      stat_ff[7:5] <= wdata[7:5];
      stat_ff[2:0] <= wdata[2:0];
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    unique case (addr)
      prwc_pkg::REG_STATUS: rd_mux = stat_ff;
      prwc_pkg::REG_P5_DATA: rd_mux = {4'h0, p5_in};
      prwc_pkg::REG_P6_DATA: rd_mux = p6_in;
      prwc_pkg::REG_IRQ_FLAG: rd_mux = {5'h00, flag_ff};
      prwc_pkg::REG_P5_DIR: rd_mux = {4'h0, p5_dir_ff};
      prwc_pkg::REG_P6_DIR: rd_mux = p6_dir_ff;
      prwc_pkg::REG_TIMER_SETUP: rd_mux = ts_ff;
      prwc_pkg::REG_PRESC_COUNT: rd_mux = presc_ff;
      prwc_pkg::REG_PULLDOWN: rd_mux = {pd_ff[7:4], 1'b0, pd_ff[2:0]};
      prwc_pkg::REG_OPENDRAIN: rd_mux = od_ff;
      prwc_pkg::REG_PULLUP: rd_mux = pu_ff;
      prwc_pkg::REG_WDOG_CTRL: rd_mux = {wd_ff[7:6], 1'b0, wd_ff[4], 4'h0};
      prwc_pkg::REG_IRQ_MASK: rd_mux = {5'h00, mask_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  // sense pins never driven while r-option is on
  wire [3:0] nxt_p5_oe = ~p5_dir_ff & ~(resistor_option_enable ? prwc_pkg::ROPT_PINS : 4'h0);
  // open-drain drives only the low level
  wire [7:0] nxt_p6_oe = ~p6_dir_ff & (~od_ff | ~p6_dout_ff);
  wire nxt_irq = (nxt_st == prwc_pkg::ST_RUN) & gie & (|pend);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
      p5_out_ff <= 4'h0;
      p5_oe_ff <= 4'h0;
      p5_pd_en_ff <= 3'h0;
      r_sense_en_ff <= 2'h0;
      p6_pins_ff <= '0;
      core_reset_ff <= 1'b1;
      sleep_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      pc_value_ff <= prwc_pkg::PC_RESET;
    end else begin
      rdata_ff <= rd_en ? rd_mux : 8'h00;
      p5_out_ff <= p5_dout_ff;
      p5_oe_ff <= nxt_p5_oe;
      p6_pins_ff.out <= p6_dout_ff;
      p6_pins_ff.oe <= nxt_p6_oe;
      // pull-downs only on the listed bits
      p5_pd_en_ff <= ~pd_ff[2:0];
      p6_pins_ff.pd_en <= ~pd_ff[7:4];
      p6_pins_ff.pu_en <= ~pu_ff;
      r_sense_en_ff <= {resistor_option_enable, resistor_option_enable};
      core_reset_ff <= (nxt_st == prwc_pkg::ST_HOLD);
      sleep_ff <= (nxt_st == prwc_pkg::ST_SLEEP);
      irq_req_ff <= nxt_irq;
      pc_load_ff <= take_vector & ~soft_rst;
      // irq-enabled change wake goes to vector
      if (init_all) begin
        pc_value_ff <= prwc_pkg::PC_RESET;
      end else if (take_vector) begin
        pc_value_ff <= prwc_pkg::PC_VECTOR;
      end
    end
  end

  property p_dir_float;
    (p6_dir_ff == 8'hff) && $stable(p6_dir_ff) |=> (p6_pins_ff.oe == 8'h00);
  endproperty
  a_dir_float: assert property (p_dir_float) else $error("floating pin driven");
  property p_reset_inputs;
    $rose(core_reset_ff) |=> (p5_oe_ff == 4'h0) && (p6_pins_ff.oe == 8'h00);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");
  property p_hold_len;
    disable iff (reset || soft_rst) $rose(core_reset_ff) |-> core_reset_ff [*8];
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("reset hold too short");
  property p_pc_zero;
    core_reset_ff |-> (pc_value_ff == prwc_pkg::PC_RESET) && !pc_load_ff;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("pc not zero in reset");
  property p_vector;
    take_vector && !soft_rst |=> pc_load_ff && (pc_value_ff == 10'h008) && !sleep_ff;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector after wake");
  property p_resume;
    wake_port && !gie && !soft_rst |=> !pc_load_ff && !sleep_ff && !core_reset_ff;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume after wake");
  property p_change_flag;
    (p6_in != snap_ff) && !soft_rst |=> flag_ff[1];
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change flag missed");
  property p_sleep_clear;
    sleep_entry && !soft_rst |=> (wdt_ff == 8'h00) && sleep_ff;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("watchdog kept on sleep");
  property p_wdt_back;
    wake_port && !soft_rst |=> wd_ff[7];
  endproperty
  a_wdt_back: assert property (p_wdt_back) else $error("watchdog off after wake");
  property p_ropt;
    resistor_option_enable && $stable(resistor_option_enable) |=> (r_sense_en_ff == 2'h3) && (p5_oe_ff[1:0] == 2'h0);
  endproperty
  a_ropt: assert property (p_ropt) else $error("r-option pins wrong");
  property p_wdt_timeout_flag;
    wdt_timeout |=> !stat_ff[4] && core_reset_ff;
  endproperty
  a_wdt_timeout_flag: assert property (p_wdt_timeout_flag) else $error("timeout not flagged");

  c_vector_wake: cover property (take_vector);
  c_plain_wake: cover property (wake_port && !gie);
  c_wdt_reset: cover property (wdt_timeout);
  c_pin_reset: cover property (in_sleep && !reset_pin_n);

endmodule // prwc_top

//--- test/prwc_pad_model.sv
// pad model for ports 5 and 6: settles each pin from device drive, outside drive (port 6 only) and pulls
// assumes one clock; an undriven pin with no pull toggles every cycle, never holds
`timescale 1ns/1ps
module prwc_pad_model (
  input wire logic sys_clk,
  input wire prwc_pkg::prwc_p6_pins_t p6_pins_ff,
  input wire logic [3:0] p5_out_ff,
  input wire logic [3:0] p5_oe_ff,
  input wire logic [2:0] p5_pd_en_ff,
  input wire logic [7:0] ext6_en,
  input wire logic [7:0] ext6_val,
  output logic [7:0] p6_in,
  output logic [3:0] p5_in
);
  logic float_ff = 1'b0;
  always @(posedge sys_clk) begin
    float_ff <= ~float_ff;
  end
  // outside driver wins, so a clash never hides a floating pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext6_en[i]) p6_in[i] = ext6_val[i];
      else if (p6_pins_ff.oe[i]) p6_in[i] = p6_pins_ff.out[i];
      else if (p6_pins_ff.pu_en[i]) p6_in[i] = 1'b1;
      else if (i < 4 && p6_pins_ff.pd_en[i % 4]) p6_in[i] = 1'b0;
      else p6_in[i] = float_ff;
    end
    for (int i = 0; i < 4; i++) begin
      if (p5_oe_ff[i]) p5_in[i] = p5_out_ff[i];
      else if (i < 3 && p5_pd_en_ff[i % 3]) p5_in[i] = 1'b0;
      else p5_in[i] = ~float_ff;
    end
  end
endmodule // prwc_pad_model

//--- test/prwc_top_tb.sv
// self-checking bench for the port, reset and wake block
// assumes the pad model on both ports and a short start-up hold
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t: %s", $time, msg); end end
module prwc_top_tb;
  localparam int HOLD = 16;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0, rd_en = 1'b0, reset_pin_n = 1'b1, hw_wdt_opt = 1'b1, wdt_tick = 1'b0;
  logic tcc_ovf = 1'b0, sleep_instr = 1'b0, gie_on_instr = 1'b0, gie_off_instr = 1'b0;
  logic wdt_clear_instr = 1'b0;
  logic [7:0] ext6_en = 8'hff, ext6_val = 8'h3c, p6_in, rdata_ff, rd_val;
  logic [3:0] p5_in, p5_out_ff, p5_oe_ff;
  logic [2:0] p5_pd_en_ff;
  logic [1:0] r_sense_en_ff;
  prwc_pkg::prwc_p6_pins_t p6_pins_ff;
  logic core_reset_ff, sleep_ff, irq_req_ff, pc_load_ff;
  logic [9:0] pc_value_ff;
  int n_fail = 0, checked = 0;
  always #5 sys_clk = ~sys_clk;
  prwc_top #(.HOLD_CYCLES(HOLD)) i_dut (.sys_clk, .reset, .addr, .wdata, .wr_en, .rd_en,
    .rdata_ff, .reset_pin_n, .hw_wdt_opt, .wdt_tick, .tcc_ovf, .sleep_instr, .gie_on_instr,
    .gie_off_instr, .wdt_clear_instr, .p5_in, .p5_out_ff, .p5_oe_ff, .p5_pd_en_ff,
    .r_sense_en_ff, .p6_in, .p6_pins_ff, .core_reset_ff, .sleep_ff, .irq_req_ff, .pc_load_ff,
    .pc_value_ff);
  prwc_pad_model i_pads (.sys_clk, .p6_pins_ff, .p5_out_ff, .p5_oe_ff, .p5_pd_en_ff,
    .ext6_en, .ext6_val, .p6_in, .p5_in);
  task automatic stop_test();
    $display("counts: %0d checked, %0d mismatched", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    rd_val = rdata_ff;
  endtask
  // 0 sleep, 1 irqs on, 2 irqs off, 3 watchdog clear
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: sleep_instr <= 1'b1;
      1: gie_on_instr <= 1'b1;
      2: gie_off_instr <= 1'b1;
      default: wdt_clear_instr <= 1'b1;
    endcase
    @(posedge sys_clk);
    {sleep_instr, gie_on_instr, gie_off_instr, wdt_clear_instr} <= 4'h0;
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      wdt_tick <= 1'b1;
      @(posedge sys_clk);
      wdt_tick <= 1'b0;
    end
    cyc(2);
  endtask
  // done: hold cycles already spent before the call
  task automatic hold_count(input int done);
    int n;
    n = 0;
    while (core_reset_ff === 1'b1 && n < HOLD + 9) begin
      cyc(1);
      n++;
    end
    `CHK(n + done >= HOLD && n + done <= HOLD + 3, 1'b1, "hold length")
  endtask
  task automatic chk_regs(input logic [7:0] st);
    logic [3:0] ra [11];
    logic [7:0] mk [11];
    logic [7:0] ex [11];
    ra = '{prwc_pkg::REG_STATUS, prwc_pkg::REG_TIMER_SETUP, prwc_pkg::REG_PRESC_COUNT,
      prwc_pkg::REG_PULLDOWN, prwc_pkg::REG_OPENDRAIN, prwc_pkg::REG_PULLUP,
      prwc_pkg::REG_WDOG_CTRL, prwc_pkg::REG_IRQ_FLAG, prwc_pkg::REG_IRQ_MASK,
      prwc_pkg::REG_P5_DIR, prwc_pkg::REG_P6_DIR};
    mk = '{8'hf8, 8'hff, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hd0, 8'h07, 8'h07, 8'h0f, 8'hff};
    ex = '{st, 8'hbf, 8'hff, 8'hf7, 8'h00, 8'hff, 8'h80, 8'h00, 8'h00, 8'h0f, 8'hff};
    `CHK(pc_value_ff, 10'h000, "pc after reset")
    `CHK({p6_pins_ff.oe, p5_oe_ff, p6_pins_ff.pu_en, p6_pins_ff.pd_en, p5_pd_en_ff}, 27'h0,
      "pins after reset")
    for (int i = 0; i < 11; i++) begin
      rd(ra[i]);
      `CHK(rd_val & mk[i], ex[i], "reset value")
    end
    $display("done reset values");
  endtask
  task automatic t_pins();
    // port 6 left to its own drive and pulls
    ext6_en <= 8'h00;
    wr(prwc_pkg::REG_P6_DATA, 8'h0f);
    wr(prwc_pkg::REG_P6_DIR, 8'h5a);
    wr(prwc_pkg::REG_P5_DIR, 8'h00);
    wr(prwc_pkg::REG_P5_DATA, 8'h05);
    wr(prwc_pkg::REG_PULLUP, 8'h0f);
    wr(prwc_pkg::REG_PULLDOWN, 8'h5a);
    cyc(2);
    `CHK({p6_pins_ff.oe, p6_pins_ff.out}, 16'ha50f, "port 6 drive")
    `CHK({p5_oe_ff, p5_out_ff}, 8'hf5, "port 5 drive")
    `CHK(p6_pins_ff.pu_en, 8'hf0, "pull-ups")
    `CHK({p6_pins_ff.pd_en, p5_pd_en_ff}, 7'b1010101, "pull-downs")
    wr(prwc_pkg::REG_OPENDRAIN, 8'hff);
    cyc(2);
    `CHK(p6_pins_ff.oe, 8'ha0, "open-drain drive")
    rd(prwc_pkg::REG_P6_DATA);
    `CHK(rd_val & 8'hf0, 8'h50, "open-drain levels")
    wr(prwc_pkg::REG_OPENDRAIN, 8'h00);
    wr(prwc_pkg::REG_PULLUP, 8'hff);
    wr(prwc_pkg::REG_PULLDOWN, 8'hff);
    $display("done pins");
  endtask
  task automatic t_ropt();
    wr(prwc_pkg::REG_P5_DIR, 8'h03);
    wr(prwc_pkg::REG_WDOG_CTRL, 8'h90);
    cyc(2);
    `CHK({r_sense_en_ff, p5_oe_ff}, 6'h3c, "r-option on")
    wr(prwc_pkg::REG_WDOG_CTRL, 8'h80);
    cyc(2);
    `CHK(r_sense_en_ff, 2'b00, "r-option off")
    $display("done r-option");
  endtask
  task automatic t_change();
    wr(prwc_pkg::REG_P6_DIR, 8'hff);
    ext6_en <= 8'hff;
    ext6_val <= 8'h3c;
    rd(prwc_pkg::REG_P6_DATA);
    `CHK(rd_val, 8'h3c, "port 6 read")
    wr(prwc_pkg::REG_IRQ_FLAG, 8'h00);
    wr(prwc_pkg::REG_IRQ_MASK, 8'h02);
    pulse(1);
    cyc(3);
    `CHK(irq_req_ff, 1'b0, "no change no irq")
    ext6_val <= 8'h34;
    cyc(3);
    `CHK(irq_req_ff, 1'b1, "change irq")
    ext6_val <= 8'h3c;
    rd(prwc_pkg::REG_P6_DATA);
    wr(prwc_pkg::REG_IRQ_FLAG, 8'h00);
    cyc(3);
    `CHK(irq_req_ff, 1'b0, "flag cleared")
    pulse(2);
    $display("done change irq");
  endtask
  task automatic t_wake(input logic gie);
    int loads;
    logic [9:0] vec;
    loads = 0;
    vec = 10'h3ff;
    wr(prwc_pkg::REG_WDOG_CTRL, 8'h00);
    rd(prwc_pkg::REG_P6_DATA);
    wr(prwc_pkg::REG_IRQ_FLAG, 8'h00);
    wr(prwc_pkg::REG_IRQ_MASK, 8'h02);
    pulse(gie ? 1 : 2);
    pulse(0);
    `CHK(sleep_ff, 1'b1, "asleep")
    rd(prwc_pkg::REG_STATUS);
    `CHK(rd_val[4:3], 2'b10, "sleep flags")
    cyc(20);
    `CHK(sleep_ff, 1'b1, "stays asleep")
    ext6_val <= 8'h3d;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      if (pc_load_ff === 1'b1) begin
        loads++;
        vec = pc_value_ff;
      end
    end
    `CHK({sleep_ff, core_reset_ff}, 2'b00, "change wake")
    `CHK(loads, gie ? 1 : 0, "vector load count")
    if (gie) `CHK(vec, 10'h008, "vector")
    rd(prwc_pkg::REG_WDOG_CTRL);
    `CHK(rd_val[7], 1'b1, "watchdog back on")
    ext6_val <= 8'h3c;
    rd(prwc_pkg::REG_P6_DATA);
    wr(prwc_pkg::REG_IRQ_FLAG, 8'h00);
    wr(prwc_pkg::REG_IRQ_MASK, 8'h00);
    $display("done wake");
  endtask
  task automatic t_wdt();
    wr(prwc_pkg::REG_TIMER_SETUP, 8'h08);
    pulse(3);
    ticks(100);
    pulse(0);
    ticks(255);
    `CHK({core_reset_ff, sleep_ff}, 2'b01, "sleep clears watchdog")
    ticks(1);
    `CHK(core_reset_ff, 1'b1, "watchdog reset")
    hold_count(2);
    chk_regs(8'h00);
    $display("done watchdog");
  endtask
  task automatic t_pin_reset();
    wr(prwc_pkg::REG_P6_DIR, 8'h00);
    reset_pin_n <= 1'b0;
    cyc(3);
    `CHK({core_reset_ff, p6_pins_ff.oe}, 9'h100, "pin reset")
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    hold_count(0);
    chk_regs(8'h00);
    $display("done pin reset");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    `CHK({core_reset_ff, p6_pins_ff.oe, p5_oe_ff}, 13'h1000, "in reset")
    @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    hold_count(0);
    chk_regs(8'h18);
    t_pins();
    t_ropt();
    t_change();
    t_wake(1'b1);
    t_wake(1'b0);
    t_wdt();
    t_pin_reset();
    stop_test();
  end
endmodule // prwc_top_tb
